// File: rtl/pdv_dividers.sv
`timescale 1ns/100ps
`default_nettype none
module pdv_dividers
#(
  parameter int R_W = 14,
  parameter int A_W = 6,
  parameter int B_W = 13,
  parameter int P_W = 6,
  parameter int DLY_TAPS = 8
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ref_clk_in,
  input wire logic fb_clk_in,
  input wire logic sync_n,
  output logic phase_comparator_ref,
  output logic phase_comparator_fb,
  input wire logic [pdv_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pdv_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pdv_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // bus side
    logic aw_hold;
    logic [IDX_W-1:0] aw_idx;
    logic w_hold;
    logic [REG_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
    // registers
    logic [REG_W-1:0] ref_lo;
    logic [REG_W-1:0] ref_hi;
    logic [REG_W-1:0] a_count;
    logic [REG_W-1:0] b_lo;
    logic [REG_W-1:0] b_hi;
    logic [REG_W-1:0] presc;
    logic [REG_W-1:0] cnt_ctrl;
    logic [REG_W-1:0] dly_sync;
    // divider datapath
    logic ref_prev;
    logic fb_prev;
    logic [R_W-1:0] r_cnt;
    logic [P_W-1:0] p_cnt;
    logic [A_W-1:0] a_left;
    logic [B_W-1:0] b_cnt;
    logic [1:0][DLY_TAPS-1:0] dly_line;
    logic [1:0] pc_out;
  } pdv_state_t;

  pdv_state_t s_q;
  pdv_state_t s_d;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [P_W-1:0] presc_base(input logic [2:0] m);
    logic [P_W-1:0] p;
    p = P_W'(1);
    unique case (pdv_presc_mode_t'(m))
      PDV_DM_2, PDV_FD_2: p = P_W'(2);
      PDV_DM_4: p = P_W'(4);
      PDV_DM_8: p = P_W'(8);
      PDV_DM_16: p = P_W'(16);
      PDV_DM_32: p = P_W'(32);
      PDV_FD_1: p = P_W'(1);
      PDV_FD_3: p = P_W'(3);
    endcase
    return p;
  endfunction

  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    return (i == IDX_REF_LO) || (i == IDX_REF_HI) || (i == IDX_A_COUNT)
      || (i == IDX_B_LO) || (i == IDX_B_HI) || (i == IDX_PRESC)
      || (i == IDX_CNT_CTRL) || (i == IDX_DLY_SYNC) || (i == IDX_STATUS);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decoded configuration

  logic [R_W-1:0] r_val;
  logic [B_W-1:0] b_val;
  logic [A_W-1:0] a_eff;
  logic [P_W-1:0] p_val;
  logic dual_mod;
  logic sync_active;
  logic ref_hold;
  logic ab_hold;
  logic [REG_W-1:0] status_word;

  assign r_val = {s_q.ref_hi[R_W-REG_W-1:0], s_q.ref_lo};
  assign b_val = {s_q.b_hi[B_W-REG_W-1:0], s_q.b_lo};
  assign p_val = presc_base(s_q.presc[2:0]);
  assign dual_mod = (s_q.presc[2:0] <= 3'(PDV_DM_32));
  // a fixed-divide prescaler leaves the A counter out entirely
  assign a_eff = dual_mod ? s_q.a_count[A_W-1:0] : '0;
  // sync pin is level sensitive here: counters stay cleared while it is low
  assign sync_active = (s_q.dly_sync[SYNC_EN_LSB +: 2] != SYNC_EN_OFF)
    && !sync_n;
  // reset bits are levels and never self-clear, so counting waits on software
  assign ref_hold = s_q.cnt_ctrl[RST_SHARED_BIT] | s_q.cnt_ctrl[RST_REF_BIT]
    | sync_active;
  assign ab_hold = s_q.cnt_ctrl[RST_SHARED_BIT] | s_q.cnt_ctrl[RST_AB_BIT]
    | sync_active;
  // status shows live levels, nothing sticky, so a short pulse may be missed
  assign status_word = {3'h0, s_q.pc_out[1], s_q.pc_out[0], sync_n, ab_hold,
    ref_hold};

  //////////////////////////////////////////////////////////////////////////
  // bus handshakes, combinational by design

  assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_hold && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign phase_comparator_ref = s_q.pc_out[0];
  assign phase_comparator_fb = s_q.pc_out[1];

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic ref_edge;
    logic fb_edge;
    logic p_tick;
    logic [P_W-1:0] p_mod;
    logic [B_W-1:0] b_eff;
    logic [1:0] raw;
    logic [1:0] tap;
    logic [1:0][DLY_W-1:0] amt;
    logic [1:0] dly_en;
    logic [REG_W-1:0] wv;
    ref_edge = 1'b0;
    fb_edge = 1'b0;
    p_tick = 1'b0;
    p_mod = '0;
    b_eff = '0;
    raw = '0;
    tap = '0;
    amt = '0;
    dly_en = '0;
    wv = '0;
    s_d = s_q;

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_idx = to_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata[REG_W-1:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    // a lone address or data beat parks until its partner arrives
    if (s_q.aw_hold && s_q.w_hold)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      wv = s_q.w_data;
      // only lane 0 carries register bits
      if (s_q.w_lane0)
      begin
        unique case (s_q.aw_idx)
          IDX_REF_LO: s_d.ref_lo = wv;
          IDX_REF_HI: s_d.ref_hi = wv & MASK_REF_HI;
          IDX_A_COUNT: s_d.a_count = wv & MASK_A_COUNT;
          IDX_B_LO: s_d.b_lo = wv;
          IDX_B_HI: s_d.b_hi = wv & MASK_B_HI;
          IDX_PRESC: s_d.presc = wv & MASK_PRESC;
          IDX_CNT_CTRL: s_d.cnt_ctrl = wv & MASK_CNT_CTRL;
          IDX_DLY_SYNC: s_d.dly_sync = wv;
          default: s_d.cnt_ctrl = s_q.cnt_ctrl;
        endcase
      end
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // read data is captured on acceptance and stands unchanged under rvalid
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = is_mapped(to_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      unique case (to_idx(s_axi_araddr))
        IDX_REF_LO: s_d.rdata = s_q.ref_lo;
        IDX_REF_HI: s_d.rdata = s_q.ref_hi;
        IDX_A_COUNT: s_d.rdata = s_q.a_count;
        IDX_B_LO: s_d.rdata = s_q.b_lo;
        IDX_B_HI: s_d.rdata = s_q.b_hi;
        IDX_PRESC: s_d.rdata = s_q.presc;
        IDX_CNT_CTRL: s_d.rdata = s_q.cnt_ctrl;
        IDX_DLY_SYNC: s_d.rdata = s_q.dly_sync;
        IDX_STATUS: s_d.rdata = status_word;
        default: s_d.rdata = REG_RESET;
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // reference divider
    s_d.ref_prev = ref_clk_in;
    s_d.fb_prev = fb_clk_in;
    // input highs or lows shorter than one system clock can be lost
    ref_edge = ref_clk_in && !s_q.ref_prev;
    fb_edge = fb_clk_in && !s_q.fb_prev;

    if (ref_hold)
    begin
      s_d.r_cnt = '0;
    end
    else if (ref_edge)
    begin
      if (r_val <= R_W'(1))
      begin
        raw[0] = 1'b1;
      end
      else if (s_q.r_cnt == r_val - R_W'(1))
      begin
        s_d.r_cnt = '0;
        raw[0] = 1'b1;
      end
      else
      begin
        s_d.r_cnt = s_q.r_cnt + R_W'(1);
      end
    end

    //////////////////////////////////////////////////////////////////////
    // feedback divider: A prescaler cycles of P+1, then the rest of B at P
    // B of zero is treated like bypass rather than stalling the loop
    b_eff = (b_val == '0) ? B_W'(1) : b_val;
    p_mod = (dual_mod && s_q.a_left != '0) ? p_val + P_W'(1) : p_val;
    // A is reloaded every held cycle so a new count applies on release
    if (ab_hold)
    begin
      s_d.p_cnt = '0;
      s_d.b_cnt = '0;
      s_d.a_left = a_eff;
    end
    else if (fb_edge)
    begin
      if (s_q.p_cnt >= p_mod - P_W'(1))
      begin
        s_d.p_cnt = '0;
        p_tick = 1'b1;
      end
      else
      begin
        s_d.p_cnt = s_q.p_cnt + P_W'(1);
      end
    end
    if (p_tick)
    begin
      if (s_q.a_left != '0)
      begin
        s_d.a_left = s_q.a_left - A_W'(1);
      end
      if (s_q.b_cnt >= b_eff - B_W'(1))
      begin
        s_d.b_cnt = '0;
        s_d.a_left = a_eff;
        raw[1] = 1'b1;
      end
      else
      begin
        s_d.b_cnt = s_q.b_cnt + B_W'(1);
      end
    end

    //////////////////////////////////////////////////////////////////////
    // delay cells, one step per system clock, so resolution is coarse
    amt[0] = s_q.dly_sync[DLY_REF_LSB +: DLY_W];
    amt[1] = s_q.dly_sync[DLY_FB_LSB +: DLY_W];
    dly_en[0] = s_q.cnt_ctrl[DLY_REF_EN_BIT];
    dly_en[1] = s_q.cnt_ctrl[DLY_FB_EN_BIT];
    // enabling a delay while a pulse is in flight can show that pulse twice
    for (int i = 0; i < 2; i++)
    begin
      s_d.dly_line[i] = {s_q.dly_line[i][DLY_TAPS-2:0], raw[i]};
      tap[i] = (amt[i] == '0) ? raw[i] : s_q.dly_line[i][amt[i] - 3'h1];
      s_d.pc_out[i] = dly_en[i] ? tap[i] : raw[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// File: rtl/pdv_pkg.sv
// Overview of operation
// - The reference divide value is 14 bits, 0 to 16383, split over two registers at indexes 0x11 and 0x12.
// - A reference divide value of zero or one passes every reference edge, i.e. divide-by-one.
// - The divided reference drives one phase comparator input and the divided feedback clock the other.
// - The reference counter is reset by its own bit, by the shared counter bit and by the sync pin.
// - The feedback divide is P times B plus A, with P selectable among 2, 4, 8, 16 and 32.
// - A 3-bit prescaler mode picks fixed divide 1, 2 or 3, or dual modulus P/P+1 for P of 2 to 32.
// - In a fixed-divide mode the A count is ignored and taken as zero, so the divide is P times B.
// - With B at one the feedback divide is the prescaler value alone, A being expected at zero.
// - The A and B counters have their own reset bit and obey the shared bit; neither clears itself.
// - A two-bit field lets the sync pin reset all three counters together; it is off after reset.
// - Each divider path has an optional delay cell whose amount is set by its own 3-bit field.
package pdv_pkg;

  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int REG_W = 8;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REF_LO = 6'h11;
  localparam logic [IDX_W-1:0] IDX_REF_HI = 6'h12;
  localparam logic [IDX_W-1:0] IDX_A_COUNT = 6'h13;
  localparam logic [IDX_W-1:0] IDX_B_LO = 6'h14;
  localparam logic [IDX_W-1:0] IDX_B_HI = 6'h15;
  localparam logic [IDX_W-1:0] IDX_PRESC = 6'h16;
  localparam logic [IDX_W-1:0] IDX_CNT_CTRL = 6'h17;
  localparam logic [IDX_W-1:0] IDX_DLY_SYNC = 6'h19;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h1F;

  // writable bits per register, the rest read as zero
  localparam logic [REG_W-1:0] MASK_REF_HI = 8'h3F;
  localparam logic [REG_W-1:0] MASK_A_COUNT = 8'h3F;
  localparam logic [REG_W-1:0] MASK_B_HI = 8'h1F;
  localparam logic [REG_W-1:0] MASK_PRESC = 8'h07;
  localparam logic [REG_W-1:0] MASK_CNT_CTRL = 8'h1F;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // counter control bits
  localparam int RST_SHARED_BIT = 0;
  localparam int RST_REF_BIT = 1;
  localparam int RST_AB_BIT = 2;
  localparam int DLY_REF_EN_BIT = 3;
  localparam int DLY_FB_EN_BIT = 4;

  // delay and sync-pin field
  localparam int DLY_W = 3;
  localparam int DLY_REF_LSB = 0;
  localparam int DLY_FB_LSB = 3;
  localparam int SYNC_EN_LSB = 6;
  localparam logic [1:0] SYNC_EN_OFF = 2'h0;

  typedef enum logic [2:0] {
    PDV_DM_2 = 3'h0,
    PDV_DM_4 = 3'h1,
    PDV_DM_8 = 3'h2,
    PDV_DM_16 = 3'h3,
    PDV_DM_32 = 3'h4,
    PDV_FD_1 = 3'h5,
    PDV_FD_2 = 3'h6,
    PDV_FD_3 = 3'h7
  } pdv_presc_mode_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: bench/pdv_clk_src.sv
`timescale 1ns/100ps
`default_nettype none
module pdv_clk_src
#(
  parameter int HALF = 150
)
(
  input wire logic run,
  output logic clk_o
);
  // stands low between bursts; HALF keeps edges off the sampling edge
  initial clk_o = 1'b0;
  always
  begin
    #HALF;
    clk_o = run & ~clk_o;
  end
endmodule
`default_nettype wire

// File: bench/pdv_dividers_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pdv_dividers_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ref_clk_in,
  input wire logic fb_clk_in,
  input wire logic phase_comparator_ref,
  input wire logic phase_comparator_fb,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // cycles since a sampled rising input edge, saturating at 15
  logic [1:0] prev_q;
  logic [3:0] qr_q;
  logic [3:0] qf_q;
  always_ff @(posedge clk_sys)
  begin
    prev_q <= {ref_clk_in, fb_clk_in};
    if (!resetn)
    begin
      qr_q <= 4'hF;
      qf_q <= 4'hF;
    end
    else
    begin
      qr_q <= (ref_clk_in && !prev_q[1]) ? 4'h0 : qr_q + 4'(qr_q != 4'hF);
      qf_q <= (fb_clk_in && !prev_q[0]) ? 4'h0 : qf_q + 4'(qf_q != 4'hF);
    end
  end
  //////////////////////////////////////////////////
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  rdata_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  ref_pulse_a: assert property (phase_comparator_ref |=>
    !phase_comparator_ref) else $error("ref pulse too long");
  fb_pulse_a: assert property (phase_comparator_fb |=>
    !phase_comparator_fb) else $error("fb pulse too long");
  ref_cause_a: assert property (phase_comparator_ref |-> qr_q <= 4'hA)
    else $error("ref pulse without edge");
  fb_cause_a: assert property (phase_comparator_fb |-> qf_q <= 4'hA)
    else $error("fb pulse without edge");
endmodule
bind pdv_dividers pdv_dividers_sva u_sva (.clk_sys, .resetn, .ref_clk_in,
  .fb_clk_in, .phase_comparator_ref, .phase_comparator_fb, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid);
`default_nettype wire

// File: bench/tb_pll_reference_feedback_dividers.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pll_reference_feedback_dividers;
  import pdv_pkg::*;
  localparam int EDGES = 200;
  logic clk_sys, resetn, sync_n, run_r, run_f, ref_clk, fb_clk, pc_r, pc_f;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt, checked, er, ef, pr, pf, cyc, n;
  pdv_dividers u_pdv_dividers (.clk_sys(clk_sys), .resetn(resetn),
    .ref_clk_in(ref_clk), .fb_clk_in(fb_clk), .sync_n(sync_n),
    .phase_comparator_ref(pc_r), .phase_comparator_fb(pc_f),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pdv_clk_src #(.HALF(150)) u_pdv_clk_src_r (.run(run_r), .clk_o(ref_clk));
  pdv_clk_src #(.HALF(260)) u_pdv_clk_src_f (.run(run_f),
    .clk_o(fb_clk));
  //////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] v,
    input logic [1:0] r);
    bq.push_back(r);
    awaddr <= {ix, 2'h0};
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] v,
    input logic [1:0] r);
    rq.push_back({r, 24'h0, v});
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // software keeps B at 3 or more or at 1, and A below B in dual modulus
  task automatic run_case(input logic [2:0] m, input logic [13:0] r,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] ctl,
    input int xr, input int xf);
    wr(IDX_CNT_CTRL, 8'h01, RESP_OKAY);
    wr(IDX_PRESC, {5'h0, m}, RESP_OKAY);
    wr(IDX_REF_LO, r[7:0], RESP_OKAY);
    wr(IDX_REF_HI, {2'h0, r[13:8]}, RESP_OKAY);
    wr(IDX_A_COUNT, a, RESP_OKAY);
    wr(IDX_B_LO, b, RESP_OKAY);
    wr(IDX_CNT_CTRL, ctl, RESP_OKAY);
    {er, ef, pr, pf} = '0;
    run_r = 1'b1;
    run_f = 1'b1;
    wait (!run_r && !run_f);
    repeat (20) @(posedge clk_sys);
    chk(34'(pr), 34'(xr));
    chk(34'(pf), 34'(xf));
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // edge counts stop each burst at exactly EDGES rising edges
  always @(posedge ref_clk)
  begin
    er++;
    if (er >= EDGES)
      run_r = 1'b0;
  end
  always @(posedge fb_clk)
  begin
    ef++;
    if (ef >= EDGES)
      run_f = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (pc_r === 1'b1)
      pr++;
    if (pc_f === 1'b1)
      pf++;
    if (cyc == 60000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    {resetn, sync_n, run_r, run_f, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    d = 8'($urandom(32'h64cdd447));
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(IDX_REF_LO, 8'h00, RESP_OKAY);
    rd(IDX_PRESC, 8'h00, RESP_OKAY);
    rd(IDX_DLY_SYNC, 8'h00, RESP_OKAY);
    wr(IDX_REF_LO, d, RESP_OKAY);
    wr(IDX_REF_HI, 8'hFF, RESP_OKAY);
    rd(IDX_REF_LO, d, RESP_OKAY);
    rd(IDX_REF_HI, MASK_REF_HI, RESP_OKAY);
    wr(6'h30, d, RESP_SLVERR);
    rd(6'h30, 8'h00, RESP_SLVERR);
    // sync pin held low throughout: disabled field must ignore it
    for (int m = 0; m < 8; m++)
    begin
      d = 8'($urandom);
      wr(IDX_DLY_SYNC, {2'h0, d[5:0]}, RESP_OKAY);
      n = (m < 5) ? (2 << m) * 3 + 1 : (m - 4) * 3;
      run_case(3'(m), 14'(m), 8'h01, 8'h03, 8'h18,
        EDGES / ((m < 2) ? 1 : m), EDGES / n);
    end
    run_case(3'h1, 14'h3, 8'h00, 8'h01, 8'h00, 66, 50);
    run_case(3'h0, 14'h3, 8'h00, 8'h03, 8'h01, 0, 0);
    run_case(3'h0, 14'h3, 8'h00, 8'h03, 8'h02, 0, 33);
    run_case(3'h0, 14'h3, 8'h00, 8'h03, 8'h04, 66, 0);
    wr(IDX_DLY_SYNC, 8'h40, RESP_OKAY);
    rd(IDX_STATUS, 8'h03, RESP_OKAY);
    run_case(3'h0, 14'h3, 8'h00, 8'h03, 8'h00, 0, 0);
    sync_n <= 1'b1;
    run_case(3'h0, 14'h3, 8'h00, 8'h03, 8'h00, 66, 33);
    tally_and_finish();
  end
endmodule
`default_nettype wire
